// [logic/bor_ctrl.sv]
`timescale 1ns/1ps
`include "bor_cfg.svh"
// What this block does
// - mode 01: software enable bit decides protection
// - start-up never waits for detector or supply
// - protection acts only once detector is ready
// - detector readiness readable in control register
// - sleep leaves protection state unchanged
// - power-up delay only when timer config low
// - mode 00: protection always off
module bor_ctrl #(
  parameter int unsigned PWRT_CYCLES = `BOR_PWRT_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // configuration and analog side
  input wire logic [1:0] brownout_mode_config,
  input wire logic powerup_timer_config_n,
  input wire logic detector_ready,
  input wire logic supply_low,
  // reset to the rest of the device, low while held
  output logic internal_reset_n
);
  // bus state
  logic hreadyout_reg;
  logic hreadyout_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic wr_pend_reg; // write data phase pending
  logic wr_pend_next;
  logic [11:0] wr_addr_reg; // address of the pending write
  logic [11:0] wr_addr_next;
  // block state
  logic sw_en_reg; // software brown-out enable
  logic sw_en_next;
  logic ready_reg; // brownout_ready_flag
  logic ready_next;
  logic prot_reg; // protection active
  logic prot_next;
  bor_pkg::bor_state_t state_reg;
  bor_pkg::bor_state_t state_next;
  logic rst_n_reg;
  logic rst_n_next;
  // timer hookup
  logic tmr_start;
  logic tmr_done;
  // helpers
  logic addr_ok;
  logic sw_en_now;
  bor_pkg::bor_stat_t stat;

  // accepted address phase
  assign addr_ok = hsel && htrans[1] && hready;
  // enable as it will stand after a write in its data phase
  assign sw_en_now = (wr_pend_reg && wr_addr_reg == `BOR_CTRL_OFS) ?
                     hwdata[`BOR_CTRL_EN_BIT] : sw_en_reg;

  always_comb begin
    stat.pwrt_n = powerup_timer_config_n;
    stat.mode = brownout_mode_config;
    stat.reset_act = !rst_n_reg;
    stat.prot = prot_reg;
  end

  // bus slave: zero wait states, read data formed from the address phase
  always_comb begin
    hreadyout_next = 1'b1;
    wr_pend_next = addr_ok && hwrite;
    wr_addr_next = addr_ok ? haddr : wr_addr_reg;
    hrdata_next = hrdata_reg;
    sw_en_next = sw_en_reg;
    if (wr_pend_reg && wr_addr_reg == `BOR_CTRL_OFS) begin
      // only the enable bit is writable, the ready flag ignores writes
      sw_en_next = hwdata[`BOR_CTRL_EN_BIT];
    end
    if (addr_ok && !hwrite) begin
      hrdata_next = 32'h0000_0000;
      if (haddr == `BOR_CTRL_OFS) begin
        hrdata_next[`BOR_CTRL_EN_BIT] = sw_en_now;
        hrdata_next[`BOR_CTRL_RDY_BIT] = ready_reg;
      end else if (haddr == `BOR_STAT_OFS) begin
        hrdata_next[4:0] = stat;
      end else begin
        // unmapped: reads zero
        hrdata_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      sw_en_reg <= `BOR_CTRL_EN_RST;
    end else begin
      hreadyout_reg <= hreadyout_next;
      hrdata_reg <= hrdata_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      sw_en_reg <= sw_en_next;
    end
  end

  // protection decision; no sleep term enters it
  always_comb begin
    ready_next = detector_ready;
    if (brownout_mode_config == `BOR_MODE_OFF) begin
      prot_next = 1'b0;
    end else if (brownout_mode_config == `BOR_MODE_SW) begin
      prot_next = sw_en_reg && ready_reg;
    end else begin
      // other modes: protection on once the detector is ready
      prot_next = ready_reg;
    end
  end

  // brown-out sequencer; it starts in run so start-up is never held off
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bor_pkg::BOR_ST_RUN: begin
        if (prot_reg && supply_low) begin
          state_next = bor_pkg::BOR_ST_BROWN;
        end
      end
      bor_pkg::BOR_ST_BROWN: begin
        if (!(prot_reg && supply_low)) begin
          if (powerup_timer_config_n) begin
            state_next = bor_pkg::BOR_ST_RUN;
          end else begin
            state_next = bor_pkg::BOR_ST_DELAY;
          end
        end
      end
      bor_pkg::BOR_ST_DELAY: begin
        if (prot_reg && supply_low) begin
          state_next = bor_pkg::BOR_ST_BROWN;
        end else if (tmr_done) begin
          state_next = bor_pkg::BOR_ST_RUN;
        end
      end
      default: begin
        state_next = bor_pkg::BOR_ST_RUN;
      end
    endcase
    rst_n_next = (state_next == bor_pkg::BOR_ST_RUN);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_reg <= 1'b0;
      prot_reg <= 1'b0;
      state_reg <= bor_pkg::BOR_ST_RUN;
      rst_n_reg <= 1'b1;
    end else begin
      ready_reg <= ready_next;
      prot_reg <= prot_next;
      state_reg <= state_next;
      rst_n_reg <= rst_n_next;
    end
  end

  // the delay counter reloads for the whole brown-out
  assign tmr_start = (state_reg == bor_pkg::BOR_ST_BROWN);

  bor_pwrt_timer #(
    .CYCLES(PWRT_CYCLES)
  ) u_pwrt (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(tmr_start),
    .done(tmr_done)
  );

  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign internal_reset_n = rst_n_reg;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  mode_off_a: assert property (brownout_mode_config == `BOR_MODE_OFF |=> !prot_reg)
    else $error("protection active in off mode");
  sw_mode_on_a: assert property (
    brownout_mode_config == `BOR_MODE_SW && sw_en_reg && ready_reg |=> prot_reg)
    else $error("software enable did not activate protection");
  sw_mode_off_a: assert property (
    brownout_mode_config == `BOR_MODE_SW && !sw_en_reg |=> !prot_reg)
    else $error("protection active with software enable clear");
  not_ready_a: assert property (!ready_reg |=> !prot_reg)
    else $error("protection active before detector ready");
  ready_read_a: assert property (
    addr_ok && !hwrite && haddr == `BOR_CTRL_OFS |=>
    hrdata[`BOR_CTRL_RDY_BIT] == $past(ready_reg))
    else $error("ready flag read back wrong");
  prot_steady_a: assert property (
    $stable(brownout_mode_config) && $stable(sw_en_reg) && $stable(ready_reg)
    |=> $stable(prot_reg))
    else $error("protection changed with no cause");
  no_hold_a: assert property (
    state_reg == bor_pkg::BOR_ST_RUN && !(prot_reg && supply_low) |=> internal_reset_n)
    else $error("reset asserted without a protected brown-out");
  brown_rst_a: assert property (prot_reg && supply_low |=> !internal_reset_n)
    else $error("brown-out did not assert reset");
  no_delay_a: assert property (
    state_reg == bor_pkg::BOR_ST_BROWN && !(prot_reg && supply_low) &&
    powerup_timer_config_n |=> internal_reset_n)
    else $error("delay added with timer config high");
  delay_a: assert property (
    state_reg == bor_pkg::BOR_ST_BROWN && !(prot_reg && supply_low) &&
    !powerup_timer_config_n |=> !internal_reset_n [*3])
    else $error("power-up delay missing");
endmodule

// [logic/bor_cfg.svh]
`ifndef BOR_CFG_SVH
`define BOR_CFG_SVH

// register byte offsets on the bus
`define BOR_CTRL_OFS 12'h000
`define BOR_STAT_OFS 12'h004

// control register field positions
`define BOR_CTRL_EN_BIT 7
`define BOR_CTRL_RDY_BIT 0

// reset values
`define BOR_CTRL_EN_RST 1'b0

// brown-out mode configuration encodings
`define BOR_MODE_OFF 2'b00
`define BOR_MODE_SW 2'b01

// power-up timer delay in microseconds, and the clock rate in MHz
`define BOR_PWRT_US 64
`define BOR_CLK_MHZ 200
`define BOR_PWRT_CYCLES (`BOR_PWRT_US * `BOR_CLK_MHZ)

`endif

// [logic/bor_pkg.sv]
package bor_pkg;

  // brown-out sequencer states
  typedef enum logic [1:0] {
    BOR_ST_RUN,
    BOR_ST_BROWN,
    BOR_ST_DELAY
  } bor_state_t;

  // status word as seen by software, high bits first
  typedef struct packed {
    logic pwrt_n;
    logic [1:0] mode;
    logic reset_act;
    logic prot;
  } bor_stat_t;

endpackage

// [logic/bor_pwrt_timer.sv]
`timescale 1ns/1ps
// power-up delay counter: reloads while start is high, counts down to zero
module bor_pwrt_timer #(
  parameter int unsigned CYCLES = 12800,
  parameter int unsigned CW = $clog2(CYCLES + 1)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  output logic done
);
  logic [CW-1:0] count_reg; // remaining cycles
  logic [CW-1:0] count_next;

  // reload on start, otherwise run down and stop at zero
  always_comb begin
    count_next = count_reg;
    if (start) begin
      count_next = CW'(CYCLES);
    end else if (count_reg != '0) begin
      count_next = count_reg - CW'(1);
    end
  end

  // register the count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign done = (count_reg == '0);
endmodule

// [sim/test_bor_ctrl.sv]
`timescale 1ns/1ps
`include "bor_cfg.svh"
// bench for the brown-out reset sequencer, driven over its ahb-lite port
module test_bor_ctrl;
  localparam int PW = 4; // shortened power-up delay
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rst_n;
  logic [11:0] haddr;
  logic [1:0] htrans, mode;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, v;
  logic pwrt_n, det_rdy, sup_low;
  int failures = 0;
  int n_tests = 0;

  // hready is the single slave's own hreadyout
  bor_ctrl #(.PWRT_CYCLES(PW)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .brownout_mode_config(mode), .powerup_timer_config_n(pwrt_n),
    .detector_ready(det_rdy), .supply_low(sup_low), .internal_reset_n(rst_n));

  // free-running 200 mhz clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // count and report a compare
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic results;
    $display("failures %0d of %0d checks", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one edge on which hready is seen high, bounded
  task automatic bus_wait;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 20) begin
        check(32'h0, 32'h1);
        results();
      end
      @(posedge hclk);
    end
  endtask

  // single word transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    bus_wait();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    bus_wait();
    rd = hrdata;
  endtask

  // wait for internal reset to reach a level within lo..hi cycles
  task automatic wait_lvl(input logic lv, input int lo, input int hi);
    int n;
    n = 0;
    while (rst_n !== lv && n < hi) begin
      @(posedge hclk);
      #1;
      n++;
    end
    check({31'h0, rst_n === lv && n >= lo}, 32'h1);
    if (rst_n !== lv) begin
      results();
    end
  endtask

  // internal reset must stay released for n cycles
  task automatic hold_hi(input int n);
    repeat (n) begin
      @(posedge hclk);
      #1;
      check({31'h0, rst_n}, 32'h1);
    end
  endtask

  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    mode = `BOR_MODE_SW;
    pwrt_n = 1'b1;
    det_rdy = 1'b0;
    sup_low = 1'b1;
    repeat (10) @(posedge hclk);
    #1;
    check({30'h0, rst_n, hreadyout}, 32'h3);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    hold_hi(6);
    xfer(1'b0, `BOR_CTRL_OFS, 32'h0, v);
    check(v, 32'h0);
    xfer(1'b0, 12'h008, 32'h0, v);
    check({v[31:1], hresp}, 32'h0);
    xfer(1'b1, `BOR_CTRL_OFS, 32'h80, v);
    hold_hi(6);
    @(posedge hclk);
    det_rdy <= 1'b1;
    xfer(1'b0, `BOR_CTRL_OFS, 32'h0, v);
    check(v, 32'h81);
    wait_lvl(1'b0, 0, 6);
    xfer(1'b0, `BOR_STAT_OFS, 32'h0, v);
    check(v, 32'h17);
    // brown-out ends with no power-up delay, then with it
    @(posedge hclk);
    sup_low <= 1'b0;
    wait_lvl(1'b1, 1, 3);
    @(posedge hclk);
    pwrt_n <= 1'b0;
    sup_low <= 1'b1;
    wait_lvl(1'b0, 0, 4);
    @(posedge hclk);
    sup_low <= 1'b0;
    wait_lvl(1'b1, PW, PW + 4);
    // software enable off: low supply ignored
    xfer(1'b1, `BOR_CTRL_OFS, 32'h0, v);
    @(posedge hclk);
    sup_low <= 1'b1;
    hold_hi(6);
    xfer(1'b0, `BOR_CTRL_OFS, 32'h0, v);
    check(v, 32'h1);
    // mode off keeps protection off despite the enable bit
    @(posedge hclk);
    mode <= `BOR_MODE_OFF;
    xfer(1'b1, `BOR_CTRL_OFS, 32'h80, v);
    hold_hi(8);
    @(posedge hclk);
    mode <= `BOR_MODE_SW;
    wait_lvl(1'b0, 0, 6);
    // enable cleared ends the brown-out, then mode 10 protects on readiness alone
    xfer(1'b1, `BOR_CTRL_OFS, 32'h0, v);
    wait_lvl(1'b1, 1, PW + 8);
    @(posedge hclk);
    mode <= 2'b10;
    wait_lvl(1'b0, 0, 6);
    results();
  end
endmodule
